/* File: epi_pkg.sv */
// Package of constants and types for the external pin interrupt unit
package epi_pkg;

  // ==========================================================
  // Sizes
  localparam int EPI_N_EXT = 3;
  localparam int EPI_N_PC = 39;
  localparam int EPI_N_GRP = 5;
  localparam int EPI_N_PIN = EPI_N_EXT + EPI_N_PC;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0] EPI_IDX_SENSE = 8'h69;
  localparam logic [7:0] EPI_IDX_EXT_MASK = 8'h3d;
  localparam logic [7:0] EPI_IDX_EXT_PEND = 8'h3c;
  localparam logic [7:0] EPI_IDX_PC_CTRL = 8'h68;
  localparam logic [7:0] EPI_IDX_PC_PEND = 8'h3b;
  localparam logic [7:0] EPI_IDX_PC_MASK0 = 8'h6b;
  localparam logic [7:0] EPI_IDX_IRQ_STAT = 8'h70;
  localparam logic [7:0] EPI_IDX_IRQ_MASK = 8'h71;

  // ==========================================================
  // Field layout
  localparam int EPI_SENSE_W = 2;
  localparam int EPI_GRP_W = 8;
  localparam int EPI_STAT_PC_POS = 3;

  // ==========================================================
  // Sense modes
  localparam logic [1:0] EPI_SENSE_LOW = 2'h0;
  localparam logic [1:0] EPI_SENSE_ANY = 2'h1;
  localparam logic [1:0] EPI_SENSE_FALL = 2'h2;
  localparam logic [1:0] EPI_SENSE_RISE = 2'h3;

  // ==========================================================
  // Bus and pin carriers
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } epi_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } epi_ahb_rsp_t;

  typedef struct packed {
    logic [EPI_N_PC-1:0] pin_change_input;
    logic [EPI_N_EXT-1:0] ext_irq_pin;
  } epi_pins_t;

  // ==========================================================
  // Whole state of the unit
  typedef struct packed {
    logic [2*EPI_N_EXT-1:0] sense;
    logic [EPI_N_EXT-1:0] ext_mask;
    logic [EPI_N_EXT-1:0] ext_pend;
    logic [EPI_N_GRP-1:0] pc_en;
    logic [EPI_N_PC-1:0] pc_mask;
    logic [EPI_N_GRP-1:0] pc_pend;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [EPI_N_PIN-1:0] sync1;
    logic [EPI_N_PIN-1:0] sync2;
    logic [EPI_N_PIN-1:0] sync3;
    logic [EPI_N_PIN-1:0] filt;
    logic wr_act;
    logic [7:0] wr_idx;
    logic [31:0] hrdata;
  } epi_state_t;

  // All registers and pipeline stages reset to zero
  localparam epi_state_t EPI_STATE_RST = '0;

endpackage

/* File: epi_unit.sv */
// External pin and pin-change interrupt unit with AHB-Lite registers
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
// Contract
// - Pin activity triggers even when driven as output
// - Group 4 fires on enabled inputs 38..32
// - Groups 3..0 fire on their eight inputs
// - Per-group masks select contributing inputs
// - Pin-change wake needs no I/O clock
// - Level mode requests while pin stays low
// - Line edges detected only while I/O clock runs
// - Low level wakes without I/O clock
// - Sense field two: low, any, fall, rise
// - Line two needs global and own mask
// - Pins sampled; pulses over one clock caught; the filter needs two equal samples, so only pulses over two clocks are sure
// - Level gone before wake gives no request
// - Edge sets pending; handler or write-one clears
// - Pending held clear in level mode
// - Lines one, zero share the sense encoding
// - Each line needs global and own mask
module epi_unit
  import epi_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register bus
  input wire epi_ahb_req_t ahb_req,
  output epi_ahb_rsp_t ahb_rsp,
  // Pins, read at the pad whatever their direction
  input wire epi_pins_t pins,
  // CPU side
  input wire logic cpu_status_register_ie,
  input wire logic io_clk_run,
  input wire logic [EPI_N_EXT-1:0] ext_irq_ack,
  input wire logic [EPI_N_GRP-1:0] pc_irq_ack,
  output logic [EPI_N_EXT-1:0] ext_irq_request,
  output logic [EPI_N_GRP-1:0] pin_change_request,
  output logic wake_request,
  output logic irq
);

  epi_state_t st;
  epi_state_t next_st;
  logic [EPI_N_PIN-1:0] chg;
  logic [EPI_N_EXT-1:0] ext_evt;
  logic [EPI_N_EXT-1:0] ext_lvl_mode;
  logic [EPI_N_EXT-1:0] ext_clr;
  logic [EPI_N_GRP-1:0] pc_evt;
  logic [EPI_N_GRP-1:0] pc_clr;
  logic [7:0] stat_clr;
  logic [31:0] rd_val;
  logic acc;
  logic [7:0] idx;
  logic mapped;
  logic wake;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    chg = '0;
    ext_evt = '0;
    ext_lvl_mode = '0;
    ext_clr = '0;
    pc_evt = '0;
    pc_clr = '0;
    stat_clr = '0;
    rd_val = '0;
    wake = 1'b0;
    acc = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    idx = ahb_req.haddr[9:2];
    mapped = (ahb_req.haddr[31:10] == 22'h000000);

    // Three stages; a change counts once stages two and three agree
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    for (int i = 0; i < EPI_N_PIN; i++) begin
      if (st.sync2[i] == st.sync3[i]) begin
        next_st.filt[i] = st.sync3[i];
      end
    end
    chg = next_st.filt ^ st.filt;

    // Dedicated lines, same encoding on every line
    for (int i = 0; i < EPI_N_EXT; i++) begin
      case (st.sense[EPI_SENSE_W*i +: EPI_SENSE_W])
        EPI_SENSE_LOW: begin
          ext_lvl_mode[i] = 1'b1;
        end
        EPI_SENSE_ANY: begin
          ext_evt[i] = chg[i];
        end
        EPI_SENSE_FALL: begin
          ext_evt[i] = chg[i] & ~next_st.filt[i];
        end
        EPI_SENSE_RISE: begin
          ext_evt[i] = chg[i] & next_st.filt[i];
        end
        default: begin
          ext_evt[i] = 1'b0;
        end
      endcase
    end
    // Edge logic sees nothing while the I/O clock is stopped
    ext_evt = ext_evt & {EPI_N_EXT{io_clk_run}};

    // Pin-change groups of eight; the top group holds seven inputs
    for (int j = 0; j < EPI_N_PC; j++) begin
      if (chg[EPI_N_EXT+j] && st.pc_mask[j]) begin
        pc_evt[j / EPI_GRP_W] = 1'b1;
      end
      // Raw pad compare so a stopped I/O clock still wakes the part
      if (st.pc_mask[j] && st.pc_en[j / EPI_GRP_W] &&
          (pins.pin_change_input[j] != st.filt[EPI_N_EXT+j])) begin
        wake = 1'b1;
      end
    end
    if (|(st.ext_mask & ext_lvl_mode & ~pins.ext_irq_pin)) begin
      wake = 1'b1;
    end

    // Register read, answered from a flop in the data phase
    case (idx)
      EPI_IDX_SENSE: rd_val[2*EPI_N_EXT-1:0] = st.sense;
      EPI_IDX_EXT_MASK: rd_val[EPI_N_EXT-1:0] = st.ext_mask;
      EPI_IDX_EXT_PEND: rd_val[EPI_N_EXT-1:0] = st.ext_pend;
      EPI_IDX_PC_CTRL: rd_val[EPI_N_GRP-1:0] = st.pc_en;
      EPI_IDX_PC_PEND: rd_val[EPI_N_GRP-1:0] = st.pc_pend;
      EPI_IDX_IRQ_STAT: rd_val[7:0] = st.irq_stat;
      EPI_IDX_IRQ_MASK: rd_val[7:0] = st.irq_mask;
      default: rd_val = '0;
    endcase
    for (int g = 0; g < EPI_N_GRP - 1; g++) begin
      if (idx == EPI_IDX_PC_MASK0 + 8'(g)) begin
        rd_val[EPI_GRP_W-1:0] = st.pc_mask[EPI_GRP_W*g +: EPI_GRP_W];
      end
    end
    if (idx == EPI_IDX_PC_MASK0 + 8'(EPI_N_GRP - 1)) begin
      rd_val[EPI_N_PC-EPI_GRP_W*4-1:0] = st.pc_mask[EPI_N_PC-1:EPI_GRP_W*4];
    end
    if (!mapped) begin
      rd_val = '0;
    end
    if (acc && !ahb_req.hwrite) begin
      next_st.hrdata = rd_val;
      if (mapped && idx == EPI_IDX_IRQ_STAT) begin
        stat_clr = 8'hff;
      end
    end
    next_st.wr_act = acc && ahb_req.hwrite && mapped;
    next_st.wr_idx = idx;

    // Register write in the data phase
    if (st.wr_act) begin
      case (st.wr_idx)
        EPI_IDX_SENSE: next_st.sense = ahb_req.hwdata[2*EPI_N_EXT-1:0];
        EPI_IDX_EXT_MASK: next_st.ext_mask = ahb_req.hwdata[EPI_N_EXT-1:0];
        EPI_IDX_EXT_PEND: ext_clr = ahb_req.hwdata[EPI_N_EXT-1:0];
        EPI_IDX_PC_CTRL: next_st.pc_en = ahb_req.hwdata[EPI_N_GRP-1:0];
        EPI_IDX_PC_PEND: pc_clr = ahb_req.hwdata[EPI_N_GRP-1:0];
        EPI_IDX_IRQ_MASK: next_st.irq_mask = ahb_req.hwdata[7:0];
        default: ext_clr = '0;
      endcase
      for (int g = 0; g < EPI_N_GRP - 1; g++) begin
        if (st.wr_idx == EPI_IDX_PC_MASK0 + 8'(g)) begin
          next_st.pc_mask[EPI_GRP_W*g +: EPI_GRP_W] = ahb_req.hwdata[EPI_GRP_W-1:0];
        end
      end
      if (st.wr_idx == EPI_IDX_PC_MASK0 + 8'(EPI_N_GRP - 1)) begin
        next_st.pc_mask[EPI_N_PC-1:EPI_GRP_W*4] =
          ahb_req.hwdata[EPI_N_PC-EPI_GRP_W*4-1:0];
      end
    end

    // Flags: a new event wins over a clear in the same cycle
    next_st.ext_pend = (st.ext_pend & ~ext_clr & ~ext_irq_ack) | ext_evt;
    next_st.ext_pend = next_st.ext_pend & ~ext_lvl_mode;
    next_st.pc_pend = (st.pc_pend & ~pc_clr & ~pc_irq_ack) | pc_evt;
    next_st.irq_stat = (st.irq_stat & ~stat_clr) |
      {pc_evt, ext_evt};
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st <= EPI_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // Level requests follow the filtered pin, so a level that vanished
  // during start-up leaves no request behind
  always_comb begin
    ext_irq_request = {EPI_N_EXT{cpu_status_register_ie}} & st.ext_mask &
      ((ext_lvl_mode & ~st.filt[EPI_N_EXT-1:0]) |
       (~ext_lvl_mode & st.ext_pend));
    pin_change_request = {EPI_N_GRP{cpu_status_register_ie}} & st.pc_en & st.pc_pend;
    wake_request = wake;
    irq = |(st.irq_stat & st.irq_mask);
    ahb_rsp.hreadyout = 1'b1;
    ahb_rsp.hresp = 1'b0;
    ahb_rsp.hrdata = st.hrdata;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_FALL_PEND: assert property (
    $fell(st.filt[0]) && $past(st.sense[1:0] == EPI_SENSE_FALL) && $past(io_clk_run)
    |-> st.ext_pend[0])
    else $error("falling edge did not set pending zero");

  AST_LEVEL_NO_PEND: assert property (
    $past(st.sense[5:4] == EPI_SENSE_LOW) && st.sense[5:4] == EPI_SENSE_LOW
    |-> !st.ext_pend[2])
    else $error("pending set in level mode");

  AST_STOPPED_NO_EDGE: assert property (
    !io_clk_run && !st.ext_pend[1] |=> !st.ext_pend[1])
    else $error("edge taken with I/O clock stopped");

  AST_GROUP4: assert property (
    $changed(st.filt[41:35]) && |($past(st.pc_mask[38:32]) &
      (st.filt[41:35] ^ $past(st.filt[41:35])))
    |-> st.pc_pend[4])
    else $error("group four missed a toggle");

  AST_GROUP0_MASKED: assert property (
    st.pc_mask[7:0] == 8'h00 && !st.pc_pend[0] |=> !st.pc_pend[0])
    else $error("masked input raised group zero");

  AST_GLOBAL_GATE: assert property (
    !cpu_status_register_ie |-> ext_irq_request == '0 && pin_change_request == '0)
    else $error("request without global enable");

  AST_LEVEL_REQ: assert property (
    st.sense[1:0] == EPI_SENSE_LOW && st.ext_mask[0] && cpu_status_register_ie &&
    !st.filt[0] |-> ext_irq_request[0])
    else $error("low level not requested");

  AST_LEVEL_GONE: assert property (
    st.sense[3:2] == EPI_SENSE_LOW && st.filt[1] |-> !ext_irq_request[1])
    else $error("request with level gone");

  AST_SYNC_FOLLOW: assert property (
    (pins.ext_irq_pin[0] == $past(pins.ext_irq_pin[0]))[*5] ##0 $past(!reset, 4)
    |-> st.filt[0] == pins.ext_irq_pin[0])
    else $error("synchroniser did not follow pin");

  AST_WAKE_LEVEL: assert property (
    st.sense[1:0] == EPI_SENSE_LOW && st.ext_mask[0] && !pins.ext_irq_pin[0]
    |-> wake_request)
    else $error("low level gave no wake");

  AST_PC_WAKE: assert property (
    st.pc_mask[0] && st.pc_en[0] && pins.pin_change_input[0] != st.filt[3] |-> wake_request)
    else $error("pin change gave no wake");

  AST_RISE_PEND: assert property (
    $rose(st.filt[2]) && $past(st.sense[5:4] == EPI_SENSE_RISE) && $past(io_clk_run)
    |-> st.ext_pend[2])
    else $error("rising edge did not set pending two");

  AST_ANY_PEND: assert property (
    $changed(st.filt[1]) && $past(st.sense[3:2] == EPI_SENSE_ANY) && $past(io_clk_run)
    |-> st.ext_pend[1])
    else $error("change did not set pending one");

  AST_GROUP0_TOGGLE: assert property (
    $changed(st.filt[10:3]) && |($past(st.pc_mask[7:0]) &
      (st.filt[10:3] ^ $past(st.filt[10:3])))
    |-> st.pc_pend[0])
    else $error("group zero missed a toggle");

  AST_ACK_CLEARS: assert property (
    ext_irq_ack[0] && !ext_evt[0] |=> !st.ext_pend[0])
    else $error("handler entry did not clear pending zero");

  AST_GROUP4_GATE: assert property (
    !st.pc_en[4] |-> !pin_change_request[4])
    else $error("group four requested while disabled");

  AST_BUS_OKAY: assert property (
    ahb_rsp.hreadyout && !ahb_rsp.hresp)
    else $error("bus answer not ready and okay");

  AST_EVENT_STATUS: assert property (
    ext_evt[0] |=> st.irq_stat[0])
    else $error("edge event not in status");

  AST_LEVEL_REQ2: assert property (
    st.sense[5:4] == EPI_SENSE_LOW && st.ext_mask[2] && cpu_status_register_ie &&
    !st.filt[2] |-> ext_irq_request[2])
    else $error("low level on line two not requested");

endmodule

/* File: epi_pin_model.sv */
// Board-side pad driver for the external pin interrupt unit
`timescale 1ns/1ps
module epi_pin_model
  import epi_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Pads, ext lines at 2:0, pin-change inputs above
  output epi_pins_t pins
);
  // ==========================================================
  // Idle pads sit high, as with a pull-up
  initial pins = '1;

  // ==========================================================
  // Pad drive
  // Each level is held well past the sampling stages, so it is never lost
  task automatic put(input int i, input logic v);
    @(posedge clk_sys);
    pins[i] <= v;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
module tb
  import epi_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ie = 1'b0;
  logic io_run = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] rd;
  logic [2:0] eack = '0;
  logic [4:0] pack = '0;
  epi_ahb_req_t req;
  epi_ahb_rsp_t rsp;
  epi_pins_t pins;
  logic [2:0] ext_req;
  logic [4:0] pc_req;
  logic wake;
  logic irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  // Single slave, so its hreadyout is the bus hready
  assign req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata, rsp.hreadyout};

  epi_unit i_dut (
    .clk_sys(clk_sys), .reset(reset), .ahb_req(req), .ahb_rsp(rsp),
    .pins(pins), .cpu_status_register_ie(ie), .io_clk_run(io_run),
    .ext_irq_ack(eack), .pc_irq_ack(pack), .ext_irq_request(ext_req),
    .pin_change_request(pc_req), .wake_request(wake), .irq(irq));
  epi_pin_model i_pins (.clk_sys(clk_sys), .pins(pins));

  // ==========================================================
  // Clock and hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  // ==========================================================
  // Tasks
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Waits on hready only; the slave may stretch either phase
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, i, 2'h0};
    hwrite <= w;
    do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    bus(1'b0, i, '0);
    chk($sformatf("reg %h", i), e, rd);
    chk("hresp", 32'h0, 32'(rsp.hresp));
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    // Let the reset-release pad edges drain through the synchroniser
    repeat (8) @(posedge clk_sys);
    rc(EPI_IDX_SENSE, 32'h0);
    rc(8'h00, 32'h0);
    wr(EPI_IDX_SENSE, 32'h3f);
    rc(EPI_IDX_SENSE, 32'h3f);
    wr(EPI_IDX_EXT_MASK, 32'h7);
    wr(EPI_IDX_IRQ_MASK, 32'hff);
    ie <= 1'b1;
    for (int i = 0; i < 3; i++)
      for (int m = 1; m < 4; m++) begin
        wr(EPI_IDX_SENSE, 32'(m) << (2 * i));
        i_pins.put(i, 1'b0);
        chk("ereq", 32'(m != 3), 32'(ext_req[i]));
        rc(EPI_IDX_EXT_PEND, 32'(m != 3) << i);
        wr(EPI_IDX_EXT_PEND, 32'h7);
        i_pins.put(i, 1'b1);
        rc(EPI_IDX_EXT_PEND, 32'(m != 2) << i);
        eack[i] <= 1'b1;
        @(posedge clk_sys);
        eack <= '0;
        rc(EPI_IDX_EXT_PEND, 32'h0);
        chk("irq", 32'h1, 32'(irq));
        rc(EPI_IDX_IRQ_STAT, 32'h1 << i);
      end
    wr(EPI_IDX_SENSE, 32'h0);
    i_pins.put(2, 1'b0);
    chk("lvl", 32'h4, 32'(ext_req));
    rc(EPI_IDX_EXT_PEND, 32'h0);
    ie <= 1'b0;
    io_run <= 1'b0;
    @(posedge clk_sys);
    chk("gie", 32'h0, 32'(ext_req));
    chk("wake", 32'h1, 32'(wake));
    wr(EPI_IDX_EXT_MASK, 32'h3);
    ie <= 1'b1;
    @(posedge clk_sys);
    chk("emsk", 32'h0, 32'(ext_req));
    wr(EPI_IDX_EXT_MASK, 32'h7);
    i_pins.put(2, 1'b1);
    chk("gone", 32'h0, 32'(ext_req));
    wr(EPI_IDX_SENSE, 32'h30);
    i_pins.put(2, 1'b0);
    i_pins.put(2, 1'b1);
    rc(EPI_IDX_EXT_PEND, 32'h0);
    io_run <= 1'b1;
    wr(EPI_IDX_PC_CTRL, 32'h1f);
    for (int g = 0; g < 5; g++)
      wr(EPI_IDX_PC_MASK0 + 8'(g), 32'hff);
    wr(EPI_IDX_PC_PEND, 32'h1f);
    for (int g = 0; g < 5; g++) begin
      i_pins.put(3 + 8 * g + (g == 4 ? 6 : 7), 1'b0);
      chk("pcr", 32'h1 << g, 32'(pc_req));
      wr(EPI_IDX_PC_PEND, 32'h1f);
    end
    wr(EPI_IDX_PC_MASK0, 32'hfe);
    i_pins.put(3, 1'b0);
    rc(EPI_IDX_PC_PEND, 32'h0);
    io_run <= 1'b0;
    i_pins.put(4, 1'b0);
    rc(EPI_IDX_PC_PEND, 32'h1);
    pack <= 5'h1;
    @(posedge clk_sys);
    pack <= '0;
    rc(EPI_IDX_PC_PEND, 32'h0);
    chk("irq", 32'h1, 32'(irq));
    wr(EPI_IDX_IRQ_MASK, 32'h0);
    @(posedge clk_sys);
    chk("irqm", 32'h0, 32'(irq));
    wr(EPI_IDX_IRQ_MASK, 32'hff);
    rc(EPI_IDX_IRQ_STAT, 32'hf8);
    @(posedge clk_sys);
    chk("irqc", 32'h0, 32'(irq));
    summarize();
  end
endmodule
